// File: bench/port_pin_function_drive_config_tb.sv
`default_nettype none

`define CHK(nm, e, g) \
  begin checks_done++; if ((e) !== (g)) begin mismatches++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module port_pin_function_drive_config_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                    ref_clk, reset_n, reg_write, reg_read, refresh;
  port_cfg_pkg::reg_addr_t reg_addr;
  port_cfg_pkg::byte_t     reg_wdata, reg_rdata, mon_exp;
  logic [39:0]             port_out_data, pin_out, pin_oe;
  logic [39:0]             pin_strong, alt_active;
  logic [159:0]            alt_out_data, alt_out_en, alt_open_drain;
  logic [79:0]             alt_select;
  logic [63:0]             rnd64;
  port_cfg_pkg::byte_t     mdl [5][9];
  port_cfg_pkg::byte_t     exp_q [$];
  int                      mismatches, checks_done, seed, p, i, r;

  port_pin_function_drive_config u_port_pin_function_drive_config (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .port_out_data(port_out_data),
    .alt_out_data(alt_out_data), .alt_out_en(alt_out_en),
    .alt_open_drain(alt_open_drain), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_strong(pin_strong), .alt_active(alt_active),
    .alt_select(alt_select));

  port_pin_partner u_port_pin_partner (
    .ref_clk(ref_clk), .refresh(refresh), .alt_out_data(alt_out_data),
    .alt_out_en(alt_out_en), .alt_open_drain(alt_open_drain));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic port_cfg_pkg::reg_addr_t base(input int n);
    return 12'hFD0 + 12'(n) * 12'h004;
  endfunction : base

  function automatic logic ok_idx(input int n);
    return n inside {1, 2, 3, 4, 7, 8};
  endfunction : ok_idx

  task automatic wr(input port_cfg_pkg::reg_addr_t a,
                    input port_cfg_pkg::byte_t d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge ref_clk);
    reg_write = 1'b0;
  endtask : wr

  task automatic rd(input port_cfg_pkg::reg_addr_t a,
                    input port_cfg_pkg::byte_t e);
    @(negedge ref_clk);
    reg_addr = a;
    reg_read = 1'b1;
    exp_q.push_back(e);
    @(negedge ref_clk);
    reg_read = 1'b0;
  endtask : rd

  task automatic sub_wr(input int n, input int x,
                        input port_cfg_pkg::byte_t d);
    wr(base(n), 8'(x));
    wr(base(n) + 12'h001, d);
    if (ok_idx(x))
      mdl[n][x] = d;
  endtask : sub_wr

  task automatic sub_rd(input int n, input int x);
    wr(base(n), 8'(x));
    rd(base(n) + 12'h001, ok_idx(x) ? mdl[n][x] : 8'h00);
  endtask : sub_rd

  task automatic refresh_pins;
    @(negedge ref_clk);
    rnd64 = {$random(seed), $random(seed)};
    refresh <= 1'b1;
    port_out_data <= rnd64[39:0];
    @(negedge ref_clk);
    refresh <= 1'b0;
    #1;
  endtask : refresh_pins

  task automatic chk_pins;
    logic       a, odm, drv, dat;
    logic [1:0] f;
    int         n, b;
    for (int k = 0; k < 40; k++)
    begin
      n = k / 8;
      b = k % 8;
      a = mdl[n][2][b];
      f = {mdl[n][8][b], mdl[n][7][b]};
      drv = a ? alt_out_en[4*k+f] : ~mdl[n][1][b];
      dat = a ? alt_out_data[4*k+f] : port_out_data[k];
      odm = mdl[n][3][b] | (a & alt_open_drain[4*k+f]);
      `CHK("pin_oe", odm ? drv & ~dat : drv, pin_oe[k])
      `CHK("pin_out", ~odm & dat, pin_out[k])
      `CHK("pin_strong", mdl[n][4][b], pin_strong[k])
      `CHK("alt_active", a, alt_active[k])
      `CHK("alt_select", f, alt_select[2*k+:2])
    end
  endtask : chk_pins

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Read data scoreboard
  // ----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (reg_read === 1'b1)
    begin
      #1;
      mon_exp = exp_q.pop_front();
      `CHK("reg_rdata", mon_exp, reg_rdata)
    end
  end

  initial
  begin
    #500000;
    mismatches++;
    $display("timeout");
    end_sim();
  end

  initial
  begin
    seed = 60;
    reset_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    refresh = 1'b0;
    port_out_data = '0;
    for (p = 0; p < 5; p++)
    begin
      for (i = 0; i < 9; i++)
        mdl[p][i] = 8'h00;
      mdl[p][1] = 8'hFF;
    end
    mdl[3][2] = 8'h01;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    refresh_pins();
    chk_pins();
    for (p = 0; p < 5; p++)
    begin
      rd(base(p), 8'h00);
      for (i = 0; i < 10; i++)
        sub_rd(p, i);
    end
    $display("test reset_values done");
    for (r = 0; r < 4; r++)
    begin
      for (p = 0; p < 5; p++)
        for (i = 0; i < 10; i++)
          sub_wr(p, i, 8'($random(seed)));
      wr(12'hFD2, 8'($random(seed)));
      rd(12'hFD2, 8'h00);
      refresh_pins();
      chk_pins();
      for (p = 0; p < 5; p++)
        for (i = 0; i < 10; i++)
          sub_rd(p, i);
      $display("test round %0d done", r);
    end
    for (r = 0; r < 10 && exp_q.size() != 0; r++)
      @(posedge ref_clk);
    if (exp_q.size() != 0)
      mismatches++;
    end_sim();
  end
endmodule : port_pin_function_drive_config_tb

`default_nettype wire

// File: bench/port_pin_partner.sv
`default_nettype none

// ----------------------------------------------------------------
// Peripheral side of every pin function
// ----------------------------------------------------------------
module port_pin_partner (
  input  wire logic         ref_clk,        // System clock
  input  wire logic         refresh,        // Pick new values
  output var  logic [159:0] alt_out_data,   // Fn data
  output var  logic [159:0] alt_out_en,     // Fn enable
  output var  logic [159:0] alt_open_drain  // Fn open drain
);
  timeunit 1ns;
  timeprecision 1ps;

  int seed;

  initial
  begin
    seed = 60;
    alt_out_data = '0;
    alt_out_en = '0;
    alt_open_drain = '0;
  end

  always @(negedge ref_clk)
  begin
    if (refresh === 1'b1)
    begin
      for (int k = 0; k < 5; k++)
      begin
        alt_out_data[32*k+:32] = $random(seed);
        alt_out_en[32*k+:32] = $random(seed);
        alt_open_drain[32*k+:32] = $random(seed);
      end
    end
  end
endmodule : port_pin_partner

`default_nettype wire

// File: logic/port_cfg_defs.svh
`ifndef PORT_CFG_DEFS_SVH
`define PORT_CFG_DEFS_SVH

// ----------------------------------------------------------------
// Register file placement
// ----------------------------------------------------------------
`define PORT_BASE_ADDR      12'hFD0
`define PORT_ADDR_STRIDE    12'h004
`define PORT_INDEX_OFFSET   12'h000
`define PORT_WINDOW_OFFSET  12'h001

// ----------------------------------------------------------------
// Subregister index values
// ----------------------------------------------------------------
`define SUB_NONE            8'h00
`define SUB_DIRECTION       8'h01
`define SUB_ALT_ENABLE      8'h02
`define SUB_OPEN_DRAIN      8'h03
`define SUB_STRONG_DRIVE    8'h04
`define SUB_CHOICE_LOW      8'h07
`define SUB_CHOICE_HIGH     8'h08

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_INDEX           8'h00
`define RST_DIRECTION       8'hFF
`define RST_ALT_ENABLE      8'h00
`define RST_ALT_ENABLE_D    8'h01
`define RST_OPEN_DRAIN      8'h00
`define RST_STRONG_DRIVE    8'h00
`define RST_CHOICE          8'h00
`define RST_READ_DATA       8'h00

// ----------------------------------------------------------------
// Port layout
// ----------------------------------------------------------------
`define PORT_D_NUMBER       3
`define MAX_PORTS           5
`define PORT_PIN_COUNT      8
`define FUNCS_PER_PIN       4

`endif

// File: logic/port_cfg_pkg.sv
`default_nettype none

package port_cfg_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [11:0] reg_addr_t;
  typedef logic [1:0]  fn_sel_t;
endpackage : port_cfg_pkg

`default_nettype wire

// File: logic/port_pin_function_drive_config.sv
`include "port_cfg_defs.svh"
`default_nettype none

// Overview of operation
// - Index 02h makes the window reach the alternate-function enable.
// - A pin with enable 0 is plain I/O whose direction is its dir bit.
// - A pin with enable 1 is driven by its peripheral function, subject to its open-drain bit.
// - The pin's two function-set bits together pick one of four functions.
// - Alt enable resets to 00h on ports A, B, C, E and 01h on port D.
// - Index 03h makes the window reach the open-drain select.
// - A pin with open-drain bit 1 never drives high, alt or not.
// - Open-drain bit 0 gives push-pull unless the peripheral asks otherwise.
// - Index 04h makes the window reach the strong-drive enable.
// - Strong-drive bit 1 raises the pin's drive strength, 0 leaves it.
// - Strong drive acts on the pin driver, peripheral-driven or not.
// - Index selects the subregister, and 00h selects nothing.
// - Direction 0 drives the output data, 1 tristates the driver.
module port_pin_function_drive_config #(
  parameter int NUM_PORTS  = `MAX_PORTS,
  parameter int PORT_WIDTH = `PORT_PIN_COUNT
) (
  input  wire logic                      ref_clk,       // System clock
  input  wire logic                      reset_n,       // Async reset
  input  wire port_cfg_pkg::reg_addr_t   reg_addr,      // Register addr
  input  wire logic                      reg_write,     // Write strobe
  input  wire logic                      reg_read,      // Read strobe
  input  wire port_cfg_pkg::byte_t       reg_wdata,     // Write data
  output var  port_cfg_pkg::byte_t       reg_rdata,     // Read data
  input  wire logic [NUM_PORTS*PORT_WIDTH-1:0]   port_out_data, // GPIO out
  input  wire logic [4*NUM_PORTS*PORT_WIDTH-1:0] alt_out_data, // Fn data
  input  wire logic [4*NUM_PORTS*PORT_WIDTH-1:0] alt_out_en,   // Fn enable
  input  wire logic [4*NUM_PORTS*PORT_WIDTH-1:0] alt_open_drain, // Fn OD
  output var  logic [NUM_PORTS*PORT_WIDTH-1:0]   pin_out,    // Pin level
  output var  logic [NUM_PORTS*PORT_WIDTH-1:0]   pin_oe,     // Pin enable
  output var  logic [NUM_PORTS*PORT_WIDTH-1:0]   pin_strong, // High drive
  output var  logic [NUM_PORTS*PORT_WIDTH-1:0]   alt_active, // Fn owns pin
  output var  logic [2*NUM_PORTS*PORT_WIDTH-1:0] alt_select  // Fn number
);

  localparam int PINS = NUM_PORTS * PORT_WIDTH;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (PORT_WIDTH != `PORT_PIN_COUNT || NUM_PORTS < 1
      || NUM_PORTS > `MAX_PORTS)
  begin : g_bad_params
    $error("Unsupported port count or width");
  end

  logic [PINS-1:0]          dir_all;
  logic [PINS-1:0]          af_all;
  logic [PINS-1:0]          od_all;
  logic [PINS-1:0]          hde_all;
  logic [PINS-1:0]          lo_all;
  logic [PINS-1:0]          hi_all;
  port_cfg_pkg::byte_t      port_rdata [NUM_PORTS];
  logic [NUM_PORTS-1:0]     hit_index;
  logic [NUM_PORTS-1:0]     hit_window;
  port_cfg_pkg::byte_t      next_rdata;

  // ----------------------------------------------------------------
  // Per-port decode and subregister banks
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    localparam port_cfg_pkg::reg_addr_t BASE =
      12'(`PORT_BASE_ADDR + p * `PORT_ADDR_STRIDE);
    localparam port_cfg_pkg::byte_t ALT_RST =
      (p == `PORT_D_NUMBER) ? `RST_ALT_ENABLE_D : `RST_ALT_ENABLE;

    port_cfg_pkg::byte_t idx;
    port_cfg_pkg::byte_t win;

    assign hit_index[p]  = (reg_addr == BASE + `PORT_INDEX_OFFSET);
    assign hit_window[p] = (reg_addr == BASE + `PORT_WINDOW_OFFSET);
    assign port_rdata[p] = hit_index[p]  ? idx :
                           hit_window[p] ? win : `RST_READ_DATA;

    port_subregister_bank #(
      .ALT_RESET (ALT_RST)
    ) u_bank (
      .ref_clk                 (ref_clk),
      .reset_n                 (reset_n),
      .index_write             (reg_write && hit_index[p]),
      .window_write            (reg_write && hit_window[p]),
      .wdata                   (reg_wdata),
      .port_subregister_index  (idx),
      .window_rdata            (win),
      .pin_direction_register  (dir_all[p*PORT_WIDTH +: PORT_WIDTH]),
      .pin_alt_function_enable (af_all[p*PORT_WIDTH +: PORT_WIDTH]),
      .pin_open_drain_select   (od_all[p*PORT_WIDTH +: PORT_WIDTH]),
      .pin_strong_drive_enable (hde_all[p*PORT_WIDTH +: PORT_WIDTH]),
      .function_choice_low     (lo_all[p*PORT_WIDTH +: PORT_WIDTH]),
      .function_choice_high    (hi_all[p*PORT_WIDTH +: PORT_WIDTH])
    );

    // Helper: no window write since reset
    logic untouched;
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
      if (!reset_n)
        untouched <= 1'b1;
      else if (reg_write && hit_window[p])
        untouched <= 1'b0;
    end

    a_alt_reset_value: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      untouched |-> af_all[p*PORT_WIDTH +: PORT_WIDTH] == ALT_RST)
      else $error("Alt enable reset value wrong");

    a_alt_window_write: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      reg_write && hit_window[p] && idx == `SUB_ALT_ENABLE
      |=> af_all[p*PORT_WIDTH +: PORT_WIDTH] == $past(reg_wdata))
      else $error("Alt enable not written via window");

    a_null_index_write: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      reg_write && hit_window[p] && idx == `SUB_NONE
      |=> $stable(af_all[p*PORT_WIDTH +: PORT_WIDTH])
          && $stable(od_all[p*PORT_WIDTH +: PORT_WIDTH])
          && $stable(hde_all[p*PORT_WIDTH +: PORT_WIDTH])
          && $stable(dir_all[p*PORT_WIDTH +: PORT_WIDTH]))
      else $error("Index zero changed a subregister");

    a_od_window_read: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      reg_read && hit_window[p] && idx == `SUB_OPEN_DRAIN
      |=> reg_rdata == $past(od_all[p*PORT_WIDTH +: PORT_WIDTH]))
      else $error("Open-drain read mismatch");

    a_hde_window_write: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      reg_write && hit_window[p] && idx == `SUB_STRONG_DRIVE
      |=> hde_all[p*PORT_WIDTH +: PORT_WIDTH] == $past(reg_wdata))
      else $error("Strong drive not written via window");

    a_unused_read_zero: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      reg_read && hit_window[p]
      && (idx == `SUB_NONE || idx > `SUB_CHOICE_HIGH
          || (idx > `SUB_STRONG_DRIVE && idx < `SUB_CHOICE_LOW))
      |=> reg_rdata == `RST_READ_DATA)
      else $error("Unused index read not zero");
  end

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = `RST_READ_DATA;
    for (int p = 0; p < NUM_PORTS; p++)
      next_rdata = next_rdata | port_rdata[p];
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= `RST_READ_DATA;
    else if (reg_read)
      reg_rdata <= next_rdata;
  end

  // ----------------------------------------------------------------
  // Pin drive per pin
  // ----------------------------------------------------------------
  for (genvar i = 0; i < PINS; i++)
  begin : g_pin
    port_cfg_pkg::fn_sel_t fn;
    logic                  want_drive;
    logic                  data;
    logic                  od_mode;

    // two set bits pick the function
    assign fn = {hi_all[i], lo_all[i]};
    assign alt_select[2*i +: 2] = fn;
    assign alt_active[i]        = af_all[i];

    // dir 0 drives, dir 1 tristates
    assign want_drive = af_all[i] ? alt_out_en[`FUNCS_PER_PIN*i + fn]
                                  : ~dir_all[i];
    assign data       = af_all[i] ? alt_out_data[`FUNCS_PER_PIN*i + fn]
                                  : port_out_data[i];

    assign od_mode   = od_all[i]
                       | (af_all[i] & alt_open_drain[`FUNCS_PER_PIN*i + fn]);
    assign pin_oe[i]  = want_drive & (~od_mode | ~data);
    assign pin_out[i] = data & ~od_mode;

    assign pin_strong[i] = hde_all[i];
  end

  // ----------------------------------------------------------------
  // Pin checks
  // ----------------------------------------------------------------
  a_od_no_high: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (pin_oe & pin_out & od_all) == '0)
    else $error("Open-drain pin driven high");

  a_gpio_input_off: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (pin_oe & ~af_all & dir_all) == '0)
    else $error("Input pin driven");

  a_gpio_push_pull: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    ((~af_all & ~dir_all & ~od_all)
     & ~(pin_oe & ~(pin_out ^ port_out_data))) == '0)
    else $error("GPIO output not driving data");

  a_alt_takes_pin: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    af_all[0] && !od_all[0]
    && !alt_open_drain[{hi_all[0], lo_all[0]}]
    |-> pin_oe[0] == alt_out_en[{hi_all[0], lo_all[0]}]
        && (!pin_oe[0]
            || pin_out[0] == alt_out_data[{hi_all[0], lo_all[0]}]))
    else $error("Alt function not driving pin");

  a_strong_follows: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    reg_write && hit_window[0] && g_port[0].idx == `SUB_STRONG_DRIVE
    |=> pin_strong[PORT_WIDTH-1:0] == $past(reg_wdata)
        && alt_active == af_all)
    else $error("Strong drive not at driver");

endmodule : port_pin_function_drive_config

`default_nettype wire

// File: logic/port_subregister_bank.sv
`include "port_cfg_defs.svh"
`default_nettype none

module port_subregister_bank #(
  parameter port_cfg_pkg::byte_t ALT_RESET = `RST_ALT_ENABLE
) (
  input  wire logic                ref_clk,         // System clock
  input  wire logic                reset_n,         // Async reset
  input  wire logic                index_write,     // Index reg write
  input  wire logic                window_write,    // Window write
  input  wire port_cfg_pkg::byte_t wdata,           // Write data
  output var  port_cfg_pkg::byte_t port_subregister_index, // Index
  output var  port_cfg_pkg::byte_t window_rdata,    // Selected value
  output var  port_cfg_pkg::byte_t pin_direction_register, // Dir
  output var  port_cfg_pkg::byte_t pin_alt_function_enable, // Alt en
  output var  port_cfg_pkg::byte_t pin_open_drain_select, // Open drain
  output var  port_cfg_pkg::byte_t pin_strong_drive_enable, // Drive
  output var  port_cfg_pkg::byte_t function_choice_low, // Fn set 1
  output var  port_cfg_pkg::byte_t function_choice_high // Fn set 2
);

  // ----------------------------------------------------------------
  // Index register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      port_subregister_index <= `RST_INDEX;
    else if (index_write)
      port_subregister_index <= wdata;
  end

  // ----------------------------------------------------------------
  // Subregisters behind the window
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_direction_register  <= `RST_DIRECTION;
      pin_alt_function_enable <= ALT_RESET;
      pin_open_drain_select   <= `RST_OPEN_DRAIN;
      pin_strong_drive_enable <= `RST_STRONG_DRIVE;
      function_choice_low     <= `RST_CHOICE;
      function_choice_high    <= `RST_CHOICE;
    end
    else if (window_write)
    begin
      case (port_subregister_index)
        `SUB_DIRECTION:    pin_direction_register  <= wdata;
        `SUB_ALT_ENABLE:   pin_alt_function_enable <= wdata;
        `SUB_OPEN_DRAIN:   pin_open_drain_select   <= wdata;
        `SUB_STRONG_DRIVE: pin_strong_drive_enable <= wdata;
        `SUB_CHOICE_LOW:   function_choice_low     <= wdata;
        `SUB_CHOICE_HIGH:  function_choice_high    <= wdata;
        default:           ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Window read selection
  // ----------------------------------------------------------------
  always_comb
  begin
    case (port_subregister_index)
      `SUB_DIRECTION:    window_rdata = pin_direction_register;
      `SUB_ALT_ENABLE:   window_rdata = pin_alt_function_enable;
      `SUB_OPEN_DRAIN:   window_rdata = pin_open_drain_select;
      `SUB_STRONG_DRIVE: window_rdata = pin_strong_drive_enable;
      `SUB_CHOICE_LOW:   window_rdata = function_choice_low;
      `SUB_CHOICE_HIGH:  window_rdata = function_choice_high;
      default:           window_rdata = `RST_READ_DATA;
    endcase
  end

endmodule : port_subregister_bank

`default_nettype wire
